// >>> fmcs_sequencer.sv
// flash rewrite command sequencer with wishbone access
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - lock bit clears only by lock program
// - erase with protect disabled unlocks block
// - program, erase, lock program can suspend
// - erase suspend: same-block program errors
// - erase suspend: erase errors, lock same-block
// - program suspend: all write commands error
// - 16-bit words, upper command byte ignored
// - FF gives read array until next command
// - 70 makes next read return status
// - 50 clears both error flags
// - 41, low word, high word programs
// - busy during program, then program error
// - program start selects status reads, except in in-place mode
// - 20 then D0 erases block
// - busy during erase, then erase error
// - erase start selects status reads, except in in-place mode
// - large part: FF/50 written twice
// - large part: 70 prefix, opposite region
// - 77 then D0 locks block
// - 71 then D0 loads lock result
// - 25 then D0 blank checks block
// - bad confirm word is sequence error

module fmcs_sequencer
  import fmcs_pkg::*;
#(
  parameter bit LARGE_ROM = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [1:0]        wb_sel_i,
  input  wire logic [15:0]       wb_dat_i,
  output logic      [15:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic      [ADDR_W-1:0] fl_raddr_o,
  input  wire logic [15:0]       fl_rdata_i,
  output logic                   fl_start_o,
  output var fmcs_op_e           fl_op_o,
  output logic      [ADDR_W-1:0] fl_op_addr_o,
  output logic      [31:0]       fl_wdata_o,
  output logic                   fl_suspend_o,
  input  wire logic              fl_done_i,
  input  wire logic              fl_fail_i
);

  fmcs_state_e       state_ff;
  fmcs_state_e       nxt_state;
  fmcs_op_e          op_ff;
  fmcs_op_e          sus_op_ff;
  fmcs_op_e          launch_op;
  logic              ack_ff;
  logic [15:0]       rd_ff;
  logic [2:0]        ctrl_ff;
  logic              busy_ff;
  logic              susp_ff;
  logic              rmode_ff;
  logic              start_ff;
  logic              pfx_low_ff;
  logic              program_error_flag_ff;
  logic              erase_error_flag_ff;
  logic              lock_state_result_ff;
  logic [7:0]        pend_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] op_addr_ff;
  logic [ADDR_W-1:0] sus_adr_ff;
  logic [31:0]       wdata_ff;
  logic [NUM_BLK-1:0] lock_vec;
  logic              seq_err;
  logic              set_pe_cmd;
  logic              set_ee_cmd;
  logic              launch;
  logic [ADDR_W-1:0] launch_adr;
  logic              to_array;
  logic              to_status;
  logic              clr_err;
  logic              lock_load;
  logic              latch_cmd;
  logic              latch_lo;
  logic              latch_hi;

  // bus decode
  wire              acc      = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire              reg_area = wb_adr_i[REG_SEL_BIT];
  wire              fwr      = acc & wb_we_i & ~reg_area & ~busy_ff
                               & (&wb_sel_i);
  wire              ctrl_wr  = acc & wb_we_i & reg_area & wb_sel_i[0]
                               & (wb_adr_i == REG_CTRL_ADR);
  wire [7:0]        cmd      = wb_dat_i[7:0];
  wire [BLK_W-1:0]  blk      = wb_adr_i[BLK_LSB +: BLK_W];
  wire [BLK_W-1:0]  pend_blk = addr_ff[BLK_LSB +: BLK_W];
  wire [BLK_W-1:0]  op_blk   = op_addr_ff[BLK_LSB +: BLK_W];
  wire [BLK_W-1:0]  sus_blk  = sus_adr_ff[BLK_LSB +: BLK_W];
  wire              low_rgn  = ~blk[BLK_W-1];

  // control bits
  wire lock_protect_disable  = ctrl_ff[CTRL_LPD_BIT];
  wire suspend_request       = ctrl_ff[CTRL_SUSP_BIT];
  wire in_place_rewrite_mode = ctrl_ff[CTRL_INPLACE_BIT];

  // status
  wire       sequencer_ready_flag = ~busy_ff;
  wire       err_any = program_error_flag_ff | erase_error_flag_ff;
  wire [7:0] status_read_value = {sequencer_ready_flag, 1'b0,
                                  erase_error_flag_ff,
                                  program_error_flag_ff, 4'h0};
  wire [15:0] stat_word = {11'h000, susp_ff, lock_state_result_ff,
                           erase_error_flag_ff, program_error_flag_ff,
                           sequencer_ready_flag};

  // lock state of addressed blocks; lock bit 0 means locked
  wire cur_raw_locked = ~lock_vec[blk];
  wire cur_locked     = cur_raw_locked & ~lock_protect_disable;
  wire pend_locked    = ~lock_vec[pend_blk] & ~lock_protect_disable;

  // acceptance of first command words
  wire first      = (state_ff == ST_IDLE);
  wire long_ok    = LARGE_ROM ? (state_ff == ST_PFX
                                 && low_rgn != pfx_low_ff) : first;
  wire susp_erase = susp_ff & (sus_op_ff == OP_ERASE);
  wire susp_prog  = susp_ff & (sus_op_ff != OP_ERASE);
  wire hit_susp   = susp_prog | (susp_erase & (blk == sus_blk));
  wire is_op      = cmd == CMD_PROGRAM || cmd == CMD_ERASE
                    || cmd == CMD_BLANK || cmd == CMD_LOCK_PROG
                    || cmd == CMD_LOCK_READ;
  wire op_ok = (cmd == CMD_PROGRAM   && long_ok && !hit_susp)
            || (cmd == CMD_ERASE     && long_ok && !susp_ff)
            || (cmd == CMD_BLANK     && long_ok && !susp_ff)
            || (cmd == CMD_LOCK_PROG && first && !hit_susp)
            || (cmd == CMD_LOCK_READ && first);

  // operation completion and suspend control
  wire op_done   = busy_ff & fl_done_i;
  wire do_susp   = busy_ff & suspend_request & ~susp_ff & ~op_done
                   & (op_ff != OP_BLANK);
  wire do_resume = susp_ff & ~suspend_request & ~busy_ff;
  wire prog_kind = (op_ff == OP_PROG) || (op_ff == OP_LOCKP);
  wire lock_clr  = op_done & (op_ff == OP_LOCKP) & ~fl_fail_i;
  wire lock_set  = op_done & (op_ff == OP_ERASE) & lock_protect_disable;

  wire nxt_pe = seq_err | set_pe_cmd | (op_done & fl_fail_i & prog_kind)
                | (program_error_flag_ff & ~clr_err);
  wire nxt_ee = seq_err | set_ee_cmd | (op_done & fl_fail_i & ~prog_kind)
                | (erase_error_flag_ff & ~clr_err);

  wire [15:0] reg_rd = (wb_adr_i == REG_CTRL_ADR) ? {13'h0000, ctrl_ff}
                     : (wb_adr_i == REG_STAT_ADR) ? stat_word : 16'h0000;
  wire [15:0] rd_mux = reg_area ? reg_rd
                     : rmode_ff ? {8'h00, status_read_value}
                     : fl_rdata_i;

  assign wb_ack_o     = ack_ff;
  assign wb_dat_o     = rd_ff;
  assign fl_raddr_o   = wb_adr_i;
  assign fl_start_o   = start_ff;
  assign fl_op_o      = op_ff;
  assign fl_op_addr_o = op_addr_ff;
  assign fl_wdata_o   = wdata_ff;
  assign fl_suspend_o = susp_ff;

  fmcs_lock_bits #(
    .NBLK (NUM_BLK)
  ) u_lock (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (lock_clr),
    .set_i  (lock_set),
    .idx_i  (op_blk),
    .lock_o (lock_vec)
  );

  // command decoder
  always_comb begin
    nxt_state  = state_ff;
    seq_err    = 1'b0;
    set_pe_cmd = 1'b0;
    set_ee_cmd = 1'b0;
    launch     = 1'b0;
    launch_op  = OP_PROG;
    launch_adr = wb_adr_i;
    to_array   = 1'b0;
    to_status  = 1'b0;
    clr_err    = 1'b0;
    lock_load  = 1'b0;
    latch_cmd  = 1'b0;
    latch_lo   = 1'b0;
    latch_hi   = 1'b0;
    if (fwr) begin
      nxt_state = ST_IDLE;
      unique case (state_ff)
        ST_IDLE, ST_PFX: begin
          if (cmd == CMD_READ_ARRAY) begin
            if (!LARGE_ROM) to_array = 1'b1;
            else if (low_rgn) nxt_state = ST_RA2;
            else seq_err = 1'b1;
          end else if (cmd == CMD_CLEAR_STATUS) begin
            if (!LARGE_ROM) clr_err = 1'b1;
            else if (low_rgn) nxt_state = ST_CS2;
            else seq_err = 1'b1;
          end else if (cmd == CMD_READ_STATUS && first) begin
            to_status = 1'b1;
            if (LARGE_ROM) nxt_state = ST_PFX;
          end else if (is_op && err_any) begin
            nxt_state = ST_IDLE;
          end else if (op_ok) begin
            latch_cmd = 1'b1;
            if (cmd == CMD_PROGRAM) nxt_state = ST_PROG_LO;
            else nxt_state = ST_CONFIRM;
          end else begin
            seq_err = 1'b1;
          end
        end
        ST_PROG_LO: begin
          latch_lo  = 1'b1;
          nxt_state = ST_PROG_HI;
        end
        ST_PROG_HI: begin
          if (pend_locked) begin
            set_pe_cmd = 1'b1;
          end else begin
            latch_hi   = 1'b1;
            launch     = 1'b1;
            launch_op  = OP_PROG;
            launch_adr = addr_ff;
          end
        end
        ST_CONFIRM: begin
          if (cmd == CMD_CONFIRM) begin
            if (pend_ff == CMD_ERASE) begin
              if (cur_locked) set_ee_cmd = 1'b1;
              else launch = 1'b1;
              launch_op = OP_ERASE;
            end else if (pend_ff == CMD_BLANK) begin
              if (cur_raw_locked) set_ee_cmd = 1'b1;
              else launch = 1'b1;
              launch_op = OP_BLANK;
            end else if (pend_ff == CMD_LOCK_PROG) begin
              launch    = 1'b1;
              launch_op = OP_LOCKP;
            end else begin
              lock_load = 1'b1;
              to_array  = 1'b1;
            end
          end else if (cmd == CMD_READ_ARRAY) begin
            to_array = 1'b1;
          end else begin
            seq_err = 1'b1;
          end
        end
        ST_RA2: begin
          if (cmd == CMD_READ_ARRAY && !low_rgn) to_array = 1'b1;
          else seq_err = 1'b1;
        end
        ST_CS2: begin
          if (cmd == CMD_CLEAR_STATUS && !low_rgn) clr_err = 1'b1;
          else seq_err = 1'b1;
        end
      endcase
    end
  end

  // bus slave: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rd_ff  <= 16'h0000;
    end else begin
      ack_ff <= acc;
      if (acc) rd_ff <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) ctrl_ff <= CTRL_RESET;
    else if (ctrl_wr) ctrl_ff <= wb_dat_i[2:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff   <= ST_IDLE;
      pfx_low_ff <= 1'b0;
      pend_ff    <= 8'h00;
      addr_ff    <= '0;
    end else begin
      state_ff <= nxt_state;
      if (fwr && first) pfx_low_ff <= low_rgn;
      if (latch_cmd) begin
        pend_ff <= cmd;
        addr_ff <= wb_adr_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) wdata_ff <= 32'h0000_0000;
    else if (latch_lo) wdata_ff[15:0] <= wb_dat_i;
    else if (latch_hi) wdata_ff[31:16] <= wb_dat_i;
  end

  // read mode: 1 selects status words
  always_ff @(posedge clk_i) begin
    if (rst_i) rmode_ff <= 1'b0;
    else if (to_array) rmode_ff <= 1'b0;
    else if (to_status) rmode_ff <= 1'b1;
    else if (launch) rmode_ff <= ~in_place_rewrite_mode;
  end

  // set wins over clear on both error flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_error_flag_ff <= 1'b0;
      erase_error_flag_ff   <= 1'b0;
      lock_state_result_ff  <= 1'b0;
    end else begin
      program_error_flag_ff <= nxt_pe;
      erase_error_flag_ff   <= nxt_ee;
      if (lock_load) lock_state_result_ff <= lock_vec[blk];
    end
  end

  // operation engine with one level of suspend
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff    <= 1'b0;
      susp_ff    <= 1'b0;
      start_ff   <= 1'b0;
      op_ff      <= OP_PROG;
      op_addr_ff <= '0;
      sus_op_ff  <= OP_PROG;
      sus_adr_ff <= '0;
    end else begin
      start_ff <= launch;
      if (launch) begin
        busy_ff    <= 1'b1;
        op_ff      <= launch_op;
        op_addr_ff <= launch_adr;
      end else if (do_resume) begin
        busy_ff    <= 1'b1;
        susp_ff    <= 1'b0;
        op_ff      <= sus_op_ff;
        op_addr_ff <= sus_adr_ff;
      end else if (op_done) begin
        busy_ff <= 1'b0;
      end else if (do_susp) begin
        busy_ff    <= 1'b0;
        susp_ff    <= 1'b1;
        sus_op_ff  <= op_ff;
        sus_adr_ff <= op_addr_ff;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lock_only_cmd: assert property (
    (|($past(lock_vec) & ~lock_vec)) |-> $past(lock_clr))
    else $error("lock bit cleared without lock program");

  a_erase_unlock: assert property (
    (op_done && op_ff == OP_ERASE && lock_protect_disable)
    |=> lock_vec[$past(op_blk)])
    else $error("erase with protect disabled left block locked");

  a_susp_enter: assert property (
    do_susp |=> susp_ff && fl_suspend_o && sequencer_ready_flag)
    else $error("suspend not entered");

  a_nested_nosusp: assert property (
    (susp_ff && busy_ff) |=> susp_ff)
    else $error("suspend lost during nested program");

  a_prog_refused: assert property (
    (fwr && first && cmd == CMD_PROGRAM && hit_susp && !err_any)
    |=> program_error_flag_ff && erase_error_flag_ff
        && state_ff == ST_IDLE)
    else $error("program during suspend not refused");

  a_erase_refused: assert property (
    (fwr && first && cmd == CMD_ERASE && susp_ff && !err_any)
    |=> program_error_flag_ff && erase_error_flag_ff)
    else $error("erase during suspend not refused");

  a_read_array: assert property (
    (fwr && first && cmd == CMD_READ_ARRAY && !LARGE_ROM) |=> !rmode_ff)
    else $error("read array mode not entered");

  a_clear_status: assert property (
    (fwr && first && cmd == CMD_CLEAR_STATUS && !LARGE_ROM && !busy_ff)
    |=> !program_error_flag_ff && !erase_error_flag_ff)
    else $error("clear status left an error flag");

  a_prog_start: assert property (
    (fwr && state_ff == ST_PROG_HI && !pend_locked)
    |=> fl_start_o && fl_op_o == OP_PROG
        && fl_wdata_o[31:16] == $past(wb_dat_i))
    else $error("program not started with high word");

  a_busy_start: assert property (
    (fl_start_o && !fl_done_i) |-> !sequencer_ready_flag ##1 busy_ff)
    else $error("ready during running operation");

  a_done_ready: assert property (
    op_done |=> sequencer_ready_flag)
    else $error("ready not restored at completion");

  a_status_mode: assert property (
    (launch && !in_place_rewrite_mode) |=> rmode_ff [*2])
    else $error("status read mode not held at start");

  a_erase_launch: assert property (
    (fwr && state_ff == ST_CONFIRM && pend_ff == CMD_ERASE
     && cmd == CMD_CONFIRM && !cur_locked)
    |=> fl_start_o && fl_op_o == OP_ERASE)
    else $error("erase not started on confirm");

  a_bad_confirm: assert property (
    (fwr && state_ff == ST_CONFIRM && cmd != CMD_CONFIRM
     && cmd != CMD_READ_ARRAY)
    |=> program_error_flag_ff && erase_error_flag_ff)
    else $error("bad confirm word not flagged");

endmodule

`default_nettype wire

// >>> fmcs_pkg.sv
// constants and types shared by the flash rewrite command sequencer
package fmcs_pkg;

  localparam int ADDR_W  = 20;
  localparam int BLK_LSB = 15;
  localparam int BLK_W   = 4;
  localparam int NUM_BLK = 16;

  // command codes, low byte of the written word
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h41;
  localparam logic [7:0] CMD_ERASE        = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_LOCK_PROG    = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ    = 8'h71;
  localparam logic [7:0] CMD_BLANK        = 8'h25;

  // register area: address bit REG_SEL_BIT set
  localparam int                REG_SEL_BIT  = 19;
  localparam logic [ADDR_W-1:0] REG_CTRL_ADR = 20'h80000;
  localparam logic [ADDR_W-1:0] REG_STAT_ADR = 20'h80002;

  localparam int         CTRL_LPD_BIT     = 0;
  localparam int         CTRL_SUSP_BIT    = 1;
  localparam int         CTRL_INPLACE_BIT = 2;
  localparam logic [2:0] CTRL_RESET       = 3'h0;

  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PERR_BIT  = 1;
  localparam int STAT_EERR_BIT  = 2;
  localparam int STAT_LOCK_BIT  = 3;
  localparam int STAT_SUSP_BIT  = 4;

  localparam int SR_READY_BIT = 7;
  localparam int SR_EFAIL_BIT = 5;
  localparam int SR_PFAIL_BIT = 4;

  typedef enum logic [1:0] {
    OP_PROG, OP_ERASE, OP_BLANK, OP_LOCKP
  } fmcs_op_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PFX, ST_PROG_LO, ST_PROG_HI, ST_CONFIRM, ST_RA2, ST_CS2
  } fmcs_state_e;

endpackage

// >>> fmcs_lock_bits.sv
// per-block lock bit array
`timescale 1ns/1ps
`default_nettype none

module fmcs_lock_bits
  import fmcs_pkg::*;
#(
  parameter int NBLK = NUM_BLK
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             set_i,
  input  wire logic [BLK_W-1:0] idx_i,
  output logic      [NBLK-1:0]  lock_o
);

  // one flop per block, 1 = unlocked
  genvar g;
  generate
    for (g = 0; g < NBLK; g++) begin : g_blk
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lock_o[g] <= 1'b1;
        end else if (set_i && idx_i == BLK_W'(g)) begin
          lock_o[g] <= 1'b1;
        end else if (clr_i && idx_i == BLK_W'(g)) begin
          lock_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> fmcs_flash_model.sv
// flash macro model: finishes each operation after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module fmcs_flash_model #(
  parameter int DLY = 30
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        suspend_i,
  input  wire logic        fail_en_i,
  input  wire logic [19:0] raddr_i,
  output logic      [15:0] rdata_o,
  output logic             done_o,
  output logic             fail_o
);
  int   cnt_ff;
  int   sav_ff;
  logic nest_ff;
  logic run;
  // a paused operation holds still unless a nested one is running
  assign run = (cnt_ff != 0) && (!suspend_i || nest_ff);
  // array words follow address bits 15:0 so reads of different low addresses differ
  assign rdata_o = raddr_i[15:0] ^ 16'h5A5A;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    fail_o <= 1'b0;
    if (rst_i) begin
      cnt_ff  <= 0;
      sav_ff  <= 0;
      nest_ff <= 1'b0;
    end else if (start_i) begin
      cnt_ff  <= DLY;
      nest_ff <= suspend_i;
      sav_ff  <= suspend_i ? cnt_ff : 0;
    end else if (run) begin
      cnt_ff <= cnt_ff - 1;
      if (cnt_ff == 1) begin
        done_o <= 1'b1;
        fail_o <= fail_en_i;
        if (nest_ff) begin
          cnt_ff  <= sav_ff;
          nest_ff <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test_fmcs_sequencer.sv
// self-checking bench for the flash rewrite command sequencer
`timescale 1ns/1ps
`default_nettype none
module test_fmcs_sequencer;
  import fmcs_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic              fail_en = 1'b0;
  logic [1:0]        sel = 2'h3;
  logic [ADDR_W-1:0] adr = '0;
  logic [15:0]       dat = '0;
  logic [15:0]       rdat, frd, s;
  logic              ack, start, susp, done, fail;
  logic [ADDR_W-1:0] raddr, op_adr, c_adr;
  logic [31:0]       wdata, c_dat;
  fmcs_op_e          op, c_op;
  int                miscompares = 0;
  int                n_tests = 0;
  int                starts = 0;
  logic [15:0]       rdat2, frd2, s2;
  logic              ack2, start2, susp2, done2, fail2;
  logic [ADDR_W-1:0] raddr2;

  fmcs_sequencer fmcs_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fl_raddr_o(raddr), .fl_rdata_i(frd), .fl_start_o(start),
    .fl_op_o(op), .fl_op_addr_o(op_adr), .fl_wdata_o(wdata),
    .fl_suspend_o(susp), .fl_done_i(done), .fl_fail_i(fail));
  fmcs_flash_model #(.DLY(30)) fmcs_flash_model_inst (.clk_i(clk_i),
    .rst_i(rst_i), .start_i(start), .suspend_i(susp), .fail_en_i(fail_en),
    .raddr_i(raddr), .rdata_o(frd), .done_o(done), .fail_o(fail));
  // large-part command set on the same bus, with a macro of its own
  fmcs_sequencer #(.LARGE_ROM(1'b1)) fmcs_sequencer_large_inst (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat2), .wb_ack_o(ack2),
    .fl_raddr_o(raddr2), .fl_rdata_i(frd2), .fl_start_o(start2),
    .fl_op_o(), .fl_op_addr_o(), .fl_wdata_o(),
    .fl_suspend_o(susp2), .fl_done_i(done2), .fl_fail_i(fail2));
  fmcs_flash_model #(.DLY(30)) fmcs_flash_model_large_inst (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start2), .suspend_i(susp2),
    .fail_en_i(fail_en), .raddr_i(raddr2), .rdata_o(frd2),
    .done_o(done2), .fail_o(fail2));

  always #12.5 clk_i = ~clk_i;
  // record every operation launched towards the small-part macro
  always @(posedge clk_i) begin
    if (start === 1'b1) begin
      starts++;
      c_op = op;
      c_adr = op_adr;
      c_dat = wdata;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [19:0] a,
                    input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    s = rdat;
    s2 = rdat2;
    chk({ack2, ack}, 2'h3);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [19:0] a);
    wb(1'b0, a, 16'h0000);
  endtask
  function automatic logic [19:0] ba(input logic [3:0] b);
    return {1'b0, b, 15'h7FFE};
  endfunction
  function automatic logic [15:0] ax(input logic [19:0] a);
    return a[15:0] ^ 16'h5A5A;
  endfunction
  task automatic stat(input logic [15:0] e);
    rd(REG_STAT_ADR);
    chk(s & 16'hFFF7, e);
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      rd(REG_STAT_ADR);
      n++;
    end while (s[STAT_READY_BIT] !== 1'b1 && n < 40);
    chk(s[STAT_READY_BIT], 1'b1);
  endtask
  task automatic cmd2(input logic [7:0] c, input logic [3:0] b);
    wr(ba(b), {8'hA7, c});
    wr(ba(b), 16'h33D0);
  endtask
  task automatic prog(input logic [19:0] a, input logic [31:0] d);
    wr(a, 16'hC341);
    wr(a, d[15:0]);
    wr(a, d[31:16]);
  endtask
  task automatic clr;
    wr(20'h00000, 16'h0050);
  endtask

  task automatic t_regs;
    stat(16'h0001);
    rd(20'h80006);
    chk(s, 16'h0000);
    wr(REG_CTRL_ADR, 16'h0005);
    rd(REG_CTRL_ADR);
    chk(s, 16'h0005);
    wr(REG_CTRL_ADR, 16'h0000);
    wr(20'h00100, 16'hABFF);
    rd(20'h00104);
    chk(s, ax(20'h00104));
    rd(20'h40000);
    chk(s, ax(20'h40000));
  endtask
  task automatic t_prog(input logic f, input logic [19:0] a);
    int n0;
    n0 = starts;
    fail_en <= f;
    prog(a, 32'hBEEF1234);
    stat(16'h0000);
    rd(20'h00200);
    chk(s, 16'h0000);
    rdy;
    chk(starts - n0, 1);
    chk(c_op, OP_PROG);
    chk(c_adr, a);
    chk(c_dat, 32'hBEEF1234);
    rd(20'h00200);
    chk(s, f ? 16'h0090 : 16'h0080);
    clr;
    stat(16'h0001);
    wr(20'h00000, 16'h00FF);
    fail_en <= 1'b0;
  endtask
  task automatic t_erase;
    fail_en <= 1'b1;
    cmd2(CMD_ERASE, 4'd3);
    rd(ba(4'd3));
    chk(s, 16'h0000);
    rdy;
    chk(c_op, OP_ERASE);
    chk(c_adr, ba(4'd3));
    rd(ba(4'd3));
    chk(s, 16'h00A0);
    clr;
    fail_en <= 1'b0;
    cmd2(CMD_LOCK_READ, 4'd3);
    rdy;
    rd(ba(4'd3));
    chk(s, ax(ba(4'd3)));
  endtask
  task automatic t_lock;
    int n0;
    cmd2(CMD_LOCK_PROG, 4'd5);
    rdy;
    chk(c_op, OP_LOCKP);
    cmd2(CMD_LOCK_READ, 4'd5);
    rdy;
    chk(s[STAT_LOCK_BIT], 1'b0);
    n0 = starts;
    cmd2(CMD_ERASE, 4'd5);
    rdy;
    chk(starts - n0, 0);
    chk(s[2:0], 3'h5);
    clr;
    cmd2(CMD_BLANK, 4'd5);
    rdy;
    chk(s[2:0], 3'h5);
    clr;
    wr(REG_CTRL_ADR, 16'h0001);
    n0 = starts;
    cmd2(CMD_ERASE, 4'd5);
    rdy;
    chk(starts - n0, 1);
    cmd2(CMD_LOCK_READ, 4'd5);
    rdy;
    chk(s[STAT_LOCK_BIT], 1'b1);
    wr(REG_CTRL_ADR, 16'h0000);
    fail_en <= 1'b1;
    cmd2(CMD_BLANK, 4'd2);
    rdy;
    chk(c_op, OP_BLANK);
    chk(s[2:0], 3'h5);
    clr;
    fail_en <= 1'b0;
  endtask
  task automatic t_bad;
    logic [7:0] cl [2];
    cl = '{CMD_ERASE, CMD_LOCK_PROG};
    for (int i = 0; i < 2; i++) begin
      wr(ba(4'd4), {8'h00, cl[i]});
      wr(ba(4'd4), 16'h12D1);
      stat(16'h0007);
      clr;
      wr(ba(4'd4), {8'h00, cl[i]});
      wr(ba(4'd4), 16'h00FF);
      stat(16'h0001);
      rd(20'h00300);
      chk(s, ax(20'h00300));
    end
  endtask
  task automatic t_esusp;
    int n0;
    cmd2(CMD_ERASE, 4'd3);
    wr(REG_CTRL_ADR, 16'h0002);
    stat(16'h0011);
    wr(20'h00000, 16'h00FF);
    rd(20'h00400);
    chk(s, ax(20'h00400));
    prog(20'h18000, 32'h1);
    stat(16'h0017);
    clr;
    cmd2(CMD_ERASE, 4'd6);
    stat(16'h0017);
    clr;
    cmd2(CMD_LOCK_PROG, 4'd3);
    stat(16'h0017);
    clr;
    n0 = starts;
    cmd2(CMD_LOCK_PROG, 4'd7);
    rdy;
    stat(16'h0011);
    prog(20'h00020, 32'h2);
    rdy;
    chk(starts - n0, 2);
    chk(c_op, OP_PROG);
    stat(16'h0011);
    wr(REG_CTRL_ADR, 16'h0000);
    stat(16'h0000);
    rdy;
    stat(16'h0001);
  endtask
  task automatic t_psusp;
    int n0;
    n0 = starts;
    prog(20'h08010, 32'h3);
    wr(REG_CTRL_ADR, 16'h0002);
    stat(16'h0011);
    prog(20'h08020, 32'h4);
    stat(16'h0017);
    clr;
    cmd2(CMD_ERASE, 4'd1);
    stat(16'h0017);
    clr;
    cmd2(CMD_LOCK_PROG, 4'd1);
    stat(16'h0017);
    clr;
    wr(REG_CTRL_ADR, 16'h0000);
    rdy;
    chk(starts - n0, 1);
    wr(REG_CTRL_ADR, 16'h0004);
    prog(20'h00170, 32'h5);
    rd(20'h00200);
    chk(s, ax(20'h00200));
    rdy;
  endtask
  task automatic t_large;
    wr(20'h40000, 16'h0070);
    rd(20'h00200);
    chk(s, 16'h0080);
    chk(s2, 16'h0080);
    prog(20'h00140, 32'h12345678);
    rd(REG_STAT_ADR);
    chk(s2 & 16'hFFF7, 16'h0000);
    rdy;
    rd(20'h00300);
    chk(s2, 16'h0080);
    wr(20'h00000, 16'h00FF);
    wr(20'h40000, 16'h00FF);
    rd(20'h00300);
    chk(s2, ax(20'h00300));
    cmd2(CMD_ERASE, 4'd9);
    rdy;
    chk(s2[2:0], 3'h7);
    wr(20'h00000, 16'h0050);
    wr(20'h40000, 16'h0050);
    rd(REG_STAT_ADR);
    chk(s2 & 16'hFFF7, 16'h0001);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    miscompares++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_large;
    t_regs;
    t_prog(1'b0, 20'h0010C);
    t_prog(1'b1, 20'h00118);
    t_erase;
    t_lock;
    t_bad;
    t_esusp;
    t_psusp;
    close_out;
  end
endmodule
`default_nettype wire
